// [core/ufp_pkg.sv]
// package: constants and carrier types for the usb fifo parallel port
// Behaviour
// - sync read: present byte, advance each clock
// - sync write: store byte each clock while low
// - sync mode drives free-running port clock at half the 25 MHz system clock
// - sync: drive bus only while enable low
// - suspended plus wakeup enabled: strobe requests resume
// - awake: strobe flushes short packet next request
// - async: write transfers on strobe falling edge, read byte popped on rising edge
// - async: bus input, driven only during read
// - async: receive flag high until read ends
// - flags undriven during reset, pull-up high
// - async: fetch next byte on read rising edge
// - async: latch byte on write falling edge
// - sync transfers on each system clock rising edge
// - sync: byte leaves when flag, strobe low
// - sync: byte enters when flag, strobe low
package ufp_pkg;
	// port clock: system clock 25 MHz stands in as the 60 MHz reference
	localparam int SYS_CLK_MHZ = 25;
	localparam int PORT_CLK_MHZ = 60;
	// depth of each buffer, log2
	localparam int BUF_AW = 4;
	// synchroniser length for pin inputs
	localparam int SYNC_LEN = 3;
	// reset value of the data bus pin outputs
	localparam logic [7:0] DATA_RST = 8'h00;

	// operating mode of the port
	typedef enum logic [0:0] {
		UFP_ASYNC = 1'b0,
		UFP_SYNC = 1'b1
	} ufp_mode_e;

	// controller strobes, all active low
	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic oe_n;
		logic send_now_wakeup_n;
	} ufp_strobe_s;

	// byte stream toward or from the usb side
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} ufp_byte_s;
endpackage

// [core/ufp_fifo.sv]
// simple synchronous byte buffer with honest full and empty
`timescale 1ns/1ps
module ufp_fifo
	import ufp_pkg::*;
#(
	parameter int AW = BUF_AW
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic pop,
	output logic [7:0] head,
	output logic empty,
	output logic full
);
	logic [7:0] mem [0:(1<<AW)-1]; // storage array
	logic [AW:0] wp_r; // write pointer with wrap bit
	logic [AW:0] rp_r; // read pointer with wrap bit

	assign empty = (wp_r == rp_r);
	assign full = (wp_r[AW] != rp_r[AW]) &&
		(wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign head = mem[rp_r[AW-1:0]];

	// storage write, no reset needed for data
	always_ff @(posedge sys_clk) begin
		if (clk_en && push && !full) begin
			mem[wp_r[AW-1:0]] <= push_data;
		end
	end

	// pointers; guarded pushes and pops never corrupt
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (clk_en) begin
			if (push && !full) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop && !empty) begin
				rp_r <= rp_r + 1'b1;
			end
		end
	end
endmodule

// [core/ufp_port.sv]
// device side of the byte-wide parallel fifo port
`timescale 1ns/1ps
module ufp_port
	import ufp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire ufp_mode_e mode, // static configuration
	input wire logic wakeup_enable, // remote wakeup configured
	input wire logic suspended, // usb suspend state
	input wire ufp_strobe_s strobe, // raw pins from controller
	input wire logic [7:0] fifo_data_bits_in, // bus pin input
	output logic [7:0] fifo_data_bits_out, // bus pin output
	output logic fifo_data_bits_oe, // bus output enable
	output logic rx_avail_n, // receive flag value
	output logic rx_avail_oe, // receive flag driver enable
	output logic tx_space_n, // space flag value
	output logic tx_space_oe, // space flag driver enable
	output logic port_clock_out, // port clock for sync mode
	output logic power_enable_n, // low while awake
	input wire ufp_byte_s usb_rx, // bytes arriving from usb
	output logic usb_rx_ready, // receive buffer can take
	output ufp_byte_s usb_tx, // bytes going to usb
	input wire logic usb_tx_ready, // usb side drains
	input wire logic bulk_in_req, // host bulk-in poll
	output logic flush_short, // send short packet now
	output logic resume_req // resume request pulse
);
	// three-stage synchronisers for the controller pins
	logic [SYNC_LEN-1:0] rd_s_r, wr_s_r, oe_s_r, sw_s_r;
	logic rd_q_r, wr_q_r, oe_q_r, sw_q_r; // debounced levels
	logic rx_empty, rx_full, tx_empty, tx_full;
	logic [7:0] rx_head;
	logic rx_pop, tx_push, rst_done_r, flush_pend_r;
	logic [7:0] rd_hold_r; // byte held on the bus
	logic rd_taken_r; // async read began with a byte waiting

	// synchronise; first stage feeds only the second
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_s_r <= '1;
			wr_s_r <= '1;
			oe_s_r <= '1;
			sw_s_r <= '1;
		end else if (clk_en) begin
			rd_s_r <= {rd_s_r[SYNC_LEN-2:0], strobe.rd_n};
			wr_s_r <= {wr_s_r[SYNC_LEN-2:0], strobe.wr_n};
			oe_s_r <= {oe_s_r[SYNC_LEN-2:0], strobe.oe_n};
			sw_s_r <= {sw_s_r[SYNC_LEN-2:0], strobe.send_now_wakeup_n};
		end
	end

	// a level counts once stages two and three agree
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_q_r <= 1'b1;
			wr_q_r <= 1'b1;
			oe_q_r <= 1'b1;
			sw_q_r <= 1'b1;
		end else if (clk_en) begin
			if (rd_s_r[1] == rd_s_r[2]) rd_q_r <= rd_s_r[2];
			if (wr_s_r[1] == wr_s_r[2]) wr_q_r <= wr_s_r[2];
			if (oe_s_r[1] == oe_s_r[2]) oe_q_r <= oe_s_r[2];
			if (sw_s_r[1] == sw_s_r[2]) sw_q_r <= sw_s_r[2];
		end
	end

	// edges of the filtered strobes
	logic rd_fall, rd_rise, wr_fall, sw_fall;
	logic rd_p_r, wr_p_r, sw_p_r;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_p_r <= 1'b1;
			wr_p_r <= 1'b1;
			sw_p_r <= 1'b1;
		end else if (clk_en) begin
			rd_p_r <= rd_q_r;
			wr_p_r <= wr_q_r;
			sw_p_r <= sw_q_r;
		end
	end
	assign rd_fall = rd_p_r && !rd_q_r;
	assign rd_rise = !rd_p_r && rd_q_r;
	assign wr_fall = wr_p_r && !wr_q_r;
	assign sw_fall = sw_p_r && !sw_q_r;

	// buffer usb to controller
	ufp_fifo #(.AW(BUF_AW)) u_rx (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.push(usb_rx.valid),
		.push_data(usb_rx.data),
		.pop(rx_pop),
		.head(rx_head),
		.empty(rx_empty),
		.full(rx_full)
	);
	assign usb_rx_ready = !rx_full;

	// buffer controller to usb; stall on usb_tx_ready
	ufp_fifo #(.AW(BUF_AW)) u_tx (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.push(tx_push),
		.push_data(fifo_data_bits_in),
		.pop(usb_tx_ready),
		.head(usb_tx.data),
		.empty(tx_empty),
		.full(tx_full)
	);
	assign usb_tx.valid = !tx_empty;

	// pop: sync every clock with strobe low
	// async on rising edge after presenting
	// empty buffer ignores reads
	// a byte landing mid-read was never shown, so it must not be popped
	assign rx_pop = !rx_empty &&
		((mode == UFP_SYNC) ? !rd_q_r : (rd_rise && rd_taken_r));
	// push: sync every clock low async on fall
	// full buffer ignores writes
	assign tx_push = !tx_full &&
		((mode == UFP_SYNC) ? !wr_q_r : wr_fall);

	// hold the byte taken at read fall in async mode
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_hold_r <= DATA_RST;
		end else if (clk_en) begin
			if (rd_fall) rd_hold_r <= rx_head;
		end
	end

	// remember whether the read found a byte; empty reads pop nothing
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_taken_r <= 1'b0;
		end else if (clk_en) begin
			if (rd_fall) rd_taken_r <= !rx_empty;
		end
	end

	// bus data from a flop in async, head in sync
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fifo_data_bits_out <= DATA_RST;
		end else if (clk_en) begin
			fifo_data_bits_out <= (mode == UFP_SYNC) ? rx_head : rd_hold_r;
		end
	end

	// bus turn-around: sync by enable
	// async only during read strobe
	assign fifo_data_bits_oe = (mode == UFP_SYNC) ? !oe_q_r : !rd_q_r;

	// flags released until first clocked edge after reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_done_r <= 1'b0;
		end else if (clk_en) begin
			rst_done_r <= 1'b1;
		end
	end
	assign rx_avail_oe = rst_done_r;
	assign tx_space_oe = rst_done_r;
	// flag high while read strobe low in async
	// also high in the rise cycle, before the pop updates empty
	assign rx_avail_n = rx_empty ||
		(mode == UFP_ASYNC && (!rd_q_r || rd_rise));
	assign tx_space_n = tx_full;

	// port clock: system clock divided by two, free running in sync mode, held low in async
	// limitation: real 60 MHz needs a faster core clock
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			port_clock_out <= 1'b0;
		end else if (clk_en) begin
			port_clock_out <= (mode == UFP_SYNC) ? !port_clock_out : 1'b0;
		end
	end

	assign power_enable_n = suspended;

	// resume request on strobe while suspended
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			resume_req <= 1'b0;
		end else if (clk_en) begin
			resume_req <= sw_fall && suspended && wakeup_enable;
		end
	end

	// flush pending until next bulk-in; set wins over clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flush_pend_r <= 1'b0;
		end else if (clk_en) begin
			if (sw_fall && !suspended) flush_pend_r <= 1'b1;
			else if (bulk_in_req) flush_pend_r <= 1'b0;
		end
	end
	assign flush_short = flush_pend_r && bulk_in_req;

	// resume only when suspended and enabled
	resume_cause_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		resume_req |-> $past(suspended) && $past(wakeup_enable))
		else $error("resume without suspend");
	// flush pending the cycle after an awake strobe
	flush_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && sw_fall && !suspended |=> flush_pend_r)
		else $error("flush not pending");
	// no pop from empty buffer
	empty_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rx_empty |-> !rx_pop)
		else $error("read from empty");
	// no push into full buffer
	full_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		tx_full |-> !tx_push)
		else $error("write into full");
	// sync bus drive follows enable
	sync_drive_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode == UFP_SYNC && oe_q_r |-> !fifo_data_bits_oe)
		else $error("bus driven without enable");
	// async bus drive only during read
	async_drive_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode == UFP_ASYNC && rd_q_r |-> !fifo_data_bits_oe)
		else $error("async bus driven idle");
	// async flag high during read
	async_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode == UFP_ASYNC && !rd_q_r |-> rx_avail_n)
		else $error("flag low during read");
	// async flag still high as the read ends
	async_rise_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode == UFP_ASYNC && rd_rise |-> rx_avail_n)
		else $error("flag low at read end");
	// sync push each cycle strobe low with space
	sync_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode == UFP_SYNC && !wr_q_r && !tx_full |-> tx_push)
		else $error("sync write missed");
	// async push exactly on write fall
	async_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode == UFP_ASYNC && tx_push |-> $fell(wr_q_r))
		else $error("async write off edge");
endmodule

// [test/ufp_ctrl.sv]
// controller model: drives strobes and bus at the fifo port
`timescale 1ns/1ps
module ufp_ctrl
	import ufp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [7:0] dev_out, // device bus drive
	input wire logic dev_oe, // device drives bus
	input wire logic space_n, // device space flag
	output ufp_strobe_s strobe, // strobe pins, active low
	output logic [7:0] bus // resolved bus level
);
	logic [7:0] drv_r = 8'h00; // our drive value
	logic drv_oe_r = 1'b0; // we drive the bus
	logic [7:0] last_r = 8'h00; // last bus level
	initial strobe = 4'hF;
	// no pull-up: a released bus flips every cycle so stale data shows
	assign bus = dev_oe ? dev_out : drv_oe_r ? drv_r : ~last_r;
	// history for the released pattern
	always @(posedge sys_clk) begin
		last_r <= bus;
	end
	// set pins on a system clock edge, hold n cycles
	task automatic pins(input logic [3:0] s, input logic oe,
		input logic [7:0] d, input int n);
		@(posedge sys_clk);
		// no write while the space flag is high
		if (s[2] == 1'b0 && space_n !== 1'b0) begin
			s[2] = 1'b1;
		end
		strobe <= s;
		drv_oe_r <= oe;
		drv_r <= d;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
endmodule

// [test/tb_ufp_port.sv]
// self-checking bench for the fifo parallel port
`timescale 1ns/1ps
module tb_ufp_port
	import ufp_pkg::*;
;
	logic sys_clk = 0, reset_n = 0, wakeup_enable = 0, suspended = 0;
	logic usb_tx_ready = 0, bulk_in_req = 0, p;
	ufp_mode_e mode = UFP_ASYNC; // configuration, switched between test phases
	ufp_byte_s usb_rx = '0, usb_tx;
	ufp_strobe_s strobe;
	logic [7:0] bus, d_out, b;
	logic d_oe, rx_n, rx_oe, tx_n, tx_oe, pclk, pwr_n, fl, res;
	int n_fail = 0, checked = 0, cyc = 0, n_res = 0, n_fl = 0;
	integer seed = 32'h227e; // fixed seed, repeatable run
	logic [7:0] exp_q[$], got_q[$]; // expected and drained bytes
	always #20 sys_clk = ~sys_clk;
	ufp_port DUT (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
		.mode(mode), .wakeup_enable(wakeup_enable),
		.suspended(suspended), .strobe(strobe), .fifo_data_bits_in(bus),
		.fifo_data_bits_out(d_out), .fifo_data_bits_oe(d_oe),
		.rx_avail_n(rx_n), .rx_avail_oe(rx_oe), .tx_space_n(tx_n),
		.tx_space_oe(tx_oe), .port_clock_out(pclk),
		.power_enable_n(pwr_n), .usb_rx(usb_rx), .usb_rx_ready(),
		.usb_tx(usb_tx), .usb_tx_ready(usb_tx_ready),
		.bulk_in_req(bulk_in_req), .flush_short(fl), .resume_req(res));
	ufp_ctrl ctl (.sys_clk(sys_clk), .dev_out(d_out), .dev_oe(d_oe),
		.space_n(tx_n), .strobe(strobe), .bus(bus));
	// usb side drains with random stalls, pulses counted, hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		usb_tx_ready <= 1'($random(seed));
		if (usb_tx.valid === 1'b1 && usb_tx_ready) got_q.push_back(usb_tx.data);
		if (res === 1'b1) n_res <= n_res + 1;
		if (fl === 1'b1) n_fl <= n_fl + 1;
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			end_sim();
		end
	end
	// compare one value, count it
	task automatic chk(input string w, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", w, e, g);
			n_fail++;
		end
	endtask
	// offer one byte from the usb side
	task automatic push_rx(input logic [7:0] d);
		@(posedge sys_clk);
		usb_rx <= {1'b1, d};
		@(posedge sys_clk);
		usb_rx <= '0;
	endtask
	// counts, verdict and stop
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		chk("rx flag oe", 0, rx_oe);
		chk("tx flag oe", 0, tx_oe);
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		ctl.pins(4'h7, 0, 0, 8);
		chk("rx flag empty", 1, rx_n);
		ctl.pins(4'hF, 0, 0, 8);
		chk("rx flag oe", 1, rx_oe);
		$display("test reset done");
		// a phantom pop on the empty read would skip the first byte
		for (int i = 0; i < 3; i++) begin
			b = 8'($random(seed));
			exp_q.push_back(b);
			push_rx(b);
		end
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 3; i++) begin
			chk("rx flag", 0, rx_n);
			ctl.pins(4'h7, 0, 0, 8);
			chk("bus oe", 1, d_oe);
			chk("read byte", exp_q[i], bus);
			ctl.pins(4'hF, 0, 0, 8);
			chk("bus oe", 0, d_oe);
		end
		chk("rx flag", 1, rx_n);
		$display("test async read done");
		exp_q = {};
		for (int i = 0; i < 4; i++) begin
			b = 8'($random(seed));
			exp_q.push_back(b);
			chk("space flag", 0, tx_n);
			ctl.pins(4'hB, 1, b, 8);
			ctl.pins(4'hF, 0, b, 8);
		end
		repeat (40) @(posedge sys_clk);
		chk("sent count", 4, 8'(got_q.size()));
		for (int i = 0; i < 4; i++) chk("sent byte", exp_q[i], got_q[i]);
		$display("test async write done");
		@(posedge sys_clk);
		mode <= UFP_SYNC;
		got_q = {};
		ctl.pins(4'hF, 0, 0, 4);
		p = pclk;
		@(posedge sys_clk);
		#1;
		chk("port clock", !p, pclk);
		// keep the byte on the bus past the strobe, filter lag
		ctl.pins(4'hB, 1, 8'hA5, 5);
		ctl.pins(4'hF, 1, 8'hA5, 30);
		// strobe pin stood low at six sampling edges: six bytes
		chk("sync count", 6, 8'(got_q.size()));
		chk("sync byte", 8'hA5, got_q[5]);
		ctl.pins(4'h7, 0, 0, 8);
		chk("bus oe", 0, d_oe);
		ctl.pins(4'hD, 0, 0, 8);
		chk("bus oe", 1, d_oe);
		// sync read: head shown, then two pops for two low samples
		exp_q = {};
		for (int i = 0; i < 4; i++) begin
			b = 8'($random(seed));
			exp_q.push_back(b);
			push_rx(b);
		end
		ctl.pins(4'hD, 0, 0, 4);
		chk("sync head", exp_q[0], bus);
		ctl.pins(4'h5, 0, 0, 1);
		ctl.pins(4'hD, 0, 0, 8);
		chk("sync pops", exp_q[2], bus);
		chk("rx flag", 0, rx_n);
		ctl.pins(4'hF, 0, 0, 8);
		$display("test sync done");
		@(posedge sys_clk);
		mode <= UFP_ASYNC;
		suspended <= 1'b1;
		wakeup_enable <= 1'b1;
		ctl.pins(4'hE, 0, 0, 8);
		ctl.pins(4'hF, 0, 0, 8);
		chk("power flag", 1, pwr_n);
		chk("resume pulses", 1, 8'(n_res));
		@(posedge sys_clk);
		suspended <= 1'b0;
		ctl.pins(4'hE, 0, 0, 8);
		ctl.pins(4'hF, 0, 0, 8);
		chk("resume pulses", 1, 8'(n_res));
		@(posedge sys_clk);
		bulk_in_req <= 1'b1;
		@(posedge sys_clk);
		bulk_in_req <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("flush pulses", 1, 8'(n_fl));
		$display("test send now done");
		end_sim();
	end
endmodule
